// >>> nwc_pkg.sv
// Constants and types for the NVM write control block
// Notes on behaviour
// [R1] Start only after 55h then AAh unlock
// [R2] Start needs program_permit and completed unlock
// [R3] target_is_code bit 7 selects code or EEPROM
// [R4] Code write stalls core two instruction cycles
// [R5] Core resumes at third instruction after start
// [R6] Software writes block words 00 to 11
// [R7] Low byte in data_low, high in data_high
// [R8] Power-up clears program_permit
// [R9] Power-up timer, 72 ms, blocks EEPROM writes
// [R10] EEPROM protect disables external EEPROM access
// [R11] EEPROM protect disables external code writes
// [R12] Code protect disables external code access
// [R13] Region select inhibits self-writes to code
// [R14] Unlock register stores nothing, reads zero
// [R15] End clears start, sets sticky done flag
// [R16] Words 0-2 buffer; word 3 erases, programs
// [R17] Code read fetches in two cycles
// [R18] Start on unexpected block word is ignored
// [R19] Done flag and enable raise irq request
// [R20] Reset during write sets program_fault
package nwc_pkg;
	// Unlock keys
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_FLAGS2 = 10'h00d;
	localparam logic [9:0] IDX_ENABLE2 = 10'h08d;
	localparam logic [9:0] IDX_DATA_LO = 10'h10c;
	localparam logic [9:0] IDX_ADDR_LO = 10'h10d;
	localparam logic [9:0] IDX_DATA_HI = 10'h10e;
	localparam logic [9:0] IDX_ADDR_HI = 10'h10f;
	localparam logic [9:0] IDX_CONTROL = 10'h18c;
	localparam logic [9:0] IDX_UNLOCK = 10'h18d;
	// Control and flag bit positions
	localparam int CTL_TGT = 7;
	localparam int CTL_FAULT = 3;
	localparam int CTL_PERMIT = 2;
	localparam int CTL_START = 1;
	localparam int CTL_READ = 0;
	localparam int FLG_DONE = 4;
	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int PWRT_MS = 72;
	localparam int PWRT_CYCLES_DEF = PWRT_MS * CLK_MHZ * 1000;
	localparam logic [1:0] SETUP_CYCLES = 2'h2;
	localparam logic [1:0] FETCH_CYCLES = 2'h2;
	// Code block layout
	localparam logic [1:0] BLK_FIRST = 2'h0;
	localparam logic [1:0] BLK_LAST = 2'h3;
	// Upper bound of the protected code region per select code
	localparam logic [15:0] REGION_LIM0 = 16'h1000;
	localparam logic [15:0] REGION_LIM1 = 16'h0800;
	localparam logic [15:0] REGION_LIM2 = 16'h0100;
	localparam logic [15:0] REGION_LIM3 = 16'h0000;
	// Unlock detector states
	typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_ARMED} nwc_unl_t;
	// Main sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_SETUP, ST_ERASE, ST_PROG} nwc_st_t;
endpackage

// >>> nwc_unlock_det.sv
// Unlock sequence detector for the NVM write control block
`timescale 1ns/10ps
module nwc_unlock_det (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic soft_reset,
	input wire logic unlock_wr,
	input wire logic other_wr,
	input wire logic consume,
	input wire logic [7:0] wdata,
	output logic armed
);
	import nwc_pkg::*;

	// ==========================================
	// Sequence state
	nwc_unl_t st_r; // Progress through the key pair

	// Keys feed only this state; nothing is kept to read back
	// [R14] no storage kept
	// [R1] ordered key detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= UNL_IDLE;
		end else if (soft_reset || consume || other_wr) begin
			// Any other write breaks or uses up the sequence
			st_r <= UNL_IDLE;
		end else if (unlock_wr) begin
			if (wdata == UNLOCK_KEY1) begin
				st_r <= UNL_KEY1;
			end else if (st_r == UNL_KEY1 && wdata == UNLOCK_KEY2) begin
				st_r <= UNL_ARMED;
			end else begin
				st_r <= UNL_IDLE;
			end
		end
	end

	assign armed = (st_r == UNL_ARMED);

	// ==========================================
	// Checks
	// [R1] armed needs AAh after 55h
	a_key_order: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(armed) |-> $past(unlock_wr) && $past(wdata) == UNLOCK_KEY2
			&& $past(st_r) == UNL_KEY1) // [R1]
		else $error("unlock armed without ordered keys");
endmodule

// >>> nwc_top.sv
// NVM write control: AHB-Lite registers, unlock, sequencer, protection
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module nwc_top #(
	parameter int PWRT_CYCLES = nwc_pkg::PWRT_CYCLES_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic soft_reset,
	input wire logic cfg_data_protect,
	input wire logic cfg_code_protect,
	input wire logic [1:0] protect_region_sel,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic mem_read,
	output logic mem_write,
	output logic mem_erase,
	output logic mem_is_code,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic core_stall,
	output logic nvm_irq_req,
	output logic ext_ee_access_en,
	output logic ext_code_read_en,
	output logic ext_code_write_en
);
	import nwc_pkg::*;

	localparam int PW_W = $clog2(PWRT_CYCLES + 1);

	// Protected-region test on a code address
	function automatic logic region_hit(input logic [1:0] sel, input logic [15:0] a);
		logic [15:0] lim;
		lim = REGION_LIM3;
		unique case (sel)
			2'h0: lim = REGION_LIM0;
			2'h1: lim = REGION_LIM1;
			2'h2: lim = REGION_LIM2;
			2'h3: lim = REGION_LIM3;
		endcase
		return a < lim;
	endfunction

	// ==========================================
	// Bus slave
	logic ph_wr_r; // Write data phase pending
	logic ph_rd_r; // Read data phase pending
	logic [9:0] ph_idx_r; // Captured register index
	logic hreadyout_r; // Ready out
	logic [31:0] hrdata_r; // Read data
	logic [7:0] rd_val; // Selected register value
	logic wr_act; // Write completes this edge
	logic take; // Address phase accepted

	assign take = hsel && htrans[1] && hready;
	assign wr_act = ph_wr_r && hready;

	// Address phase capture; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_r <= 1'b0;
			ph_rd_r <= 1'b0;
			ph_idx_r <= 10'h000;
			hreadyout_r <= 1'b1;
		end else begin
			ph_wr_r <= take && hwrite;
			ph_rd_r <= take && !hwrite;
			hreadyout_r <= !(take && !hwrite);
			if (take) begin
				ph_idx_r <= haddr[11:2];
			end
		end
	end

	// Read data registered in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= RDATA_RST;
		end else if (ph_rd_r) begin
			hrdata_r <= {24'h000000, rd_val};
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;

	// ==========================================
	// Registers
	logic [7:0] dlo_r, dhi_r, alo_r, ahi_r; // Data and address bytes
	logic tgt_r; // target_is_code
	logic permit_r; // program_permit
	logic fault_r; // program_fault
	logic start_r; // Write in progress
	logic read_r; // Read in progress
	logic done_r; // nvm_done_flag
	logic done_en_r; // nvm_done_irq_en
	logic w_ctl, w_unl, w_flg, w_en, w_dlo, w_dhi, w_alo, w_ahi; // Write strobes
	logic [15:0] code_addr; // Full code address

	assign w_ctl = wr_act && ph_idx_r == IDX_CONTROL;
	assign w_unl = wr_act && ph_idx_r == IDX_UNLOCK;
	assign w_flg = wr_act && ph_idx_r == IDX_FLAGS2;
	assign w_en = wr_act && ph_idx_r == IDX_ENABLE2;
	assign w_dlo = wr_act && ph_idx_r == IDX_DATA_LO;
	assign w_dhi = wr_act && ph_idx_r == IDX_DATA_HI;
	assign w_alo = wr_act && ph_idx_r == IDX_ADDR_LO;
	assign w_ahi = wr_act && ph_idx_r == IDX_ADDR_HI;
	assign code_addr = {ahi_r, alo_r};

	// Read mux; unlock and unmapped read zero
	// [R14] unlock reads zero
	always_comb begin
		rd_val = REG_RST;
		case (ph_idx_r)
			IDX_FLAGS2: rd_val[FLG_DONE] = done_r;
			IDX_ENABLE2: rd_val[FLG_DONE] = done_en_r;
			IDX_DATA_LO: rd_val = dlo_r;
			IDX_DATA_HI: rd_val = dhi_r;
			IDX_ADDR_LO: rd_val = alo_r;
			IDX_ADDR_HI: rd_val = ahi_r;
			IDX_CONTROL: rd_val = {tgt_r, 3'h0, fault_r, permit_r, start_r, read_r};
			default: rd_val = REG_RST;
		endcase
	end

	// ==========================================
	// Unlock and start acceptance
	logic armed; // Key pair seen
	logic pwrt_busy; // Power-up timer running
	logic [1:0] exp_idx_r; // Next expected block word
	logic accept, go, code_ok, rd_go, fin;
	nwc_st_t st_r, st_nxt;
	logic [1:0] cnt_r, cnt_nxt, widx_r, widx_nxt;

	nwc_unlock_det u_unlock (
		.hclk(hclk),
		.hresetn(hresetn),
		.soft_reset(soft_reset),
		.unlock_wr(w_unl),
		.other_wr(wr_act && !w_unl && !w_ctl),
		.consume(w_ctl),
		.wdata(hwdata[7:0]),
		.armed(armed)
	);

	// [R2] permit and unlock both required
	assign accept = w_ctl && hwdata[CTL_START] && !start_r && st_r == ST_IDLE
		&& armed && permit_r && !soft_reset;
	// [R18] unexpected block word ignored; [R13] region inhibit
	assign code_ok = (alo_r[1:0] == exp_idx_r || alo_r[1:0] == BLK_FIRST)
		&& !region_hit(protect_region_sel, code_addr);
	// [R3] target bit routes the request; [R9] timer blocks EEPROM
	assign go = accept && (hwdata[CTL_TGT] ? code_ok : !pwrt_busy);
	assign rd_go = w_ctl && hwdata[CTL_READ] && !go && st_r == ST_IDLE && !soft_reset;

	// ==========================================
	// Power-up timer
	logic [PW_W-1:0] pwrt_cnt_r; // Cycles since power-on

	// [R9] counts once after power-on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwrt_cnt_r <= '0;
		end else if (pwrt_busy) begin
			pwrt_cnt_r <= pwrt_cnt_r + 1'b1;
		end
	end

	assign pwrt_busy = pwrt_cnt_r != PW_W'(PWRT_CYCLES);

	// ==========================================
	// Sequencer
	logic [15:0] buf_r [4]; // Code block buffer

	// [R16] buffer words, erase and program on last
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		widx_nxt = widx_r;
		fin = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (go) begin
					st_nxt = ST_SETUP;
					cnt_nxt = SETUP_CYCLES - 2'h1;
				end else if (rd_go) begin
					st_nxt = ST_FETCH;
					cnt_nxt = FETCH_CYCLES - 2'h1;
				end
			end
			ST_FETCH: begin
				cnt_nxt = cnt_r - 2'h1;
				if (cnt_r == 2'h0) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_SETUP: begin
				cnt_nxt = cnt_r - 2'h1;
				widx_nxt = BLK_FIRST;
				if (cnt_r == 2'h0) begin
					if (!tgt_r) begin
						st_nxt = ST_PROG;
					end else if (alo_r[1:0] == BLK_LAST) begin
						st_nxt = ST_ERASE;
					end else begin
						st_nxt = ST_IDLE;
						fin = 1'b1;
					end
				end
			end
			ST_ERASE: begin
				if (mem_ack) begin
					st_nxt = ST_PROG;
				end
			end
			ST_PROG: begin
				if (mem_ack) begin
					if (tgt_r && widx_r != BLK_LAST) begin
						widx_nxt = widx_r + 2'h1;
					end else begin
						st_nxt = ST_IDLE;
						fin = 1'b1;
					end
				end
			end
		endcase
		if (soft_reset) begin
			st_nxt = ST_IDLE;
			fin = 1'b0;
		end
	end

	// State, counters and block bookkeeping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_IDLE;
			cnt_r <= 2'h0;
			widx_r <= BLK_FIRST;
			exp_idx_r <= BLK_FIRST;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			widx_r <= widx_nxt;
			if (go && hwdata[CTL_TGT]) begin
				exp_idx_r <= alo_r[1:0] + 2'h1;
			end
		end
	end

	// [R7] low byte from data_low, high from data_high
	always_ff @(posedge hclk) begin
		if (go && hwdata[CTL_TGT]) begin
			buf_r[alo_r[1:0]] <= {dhi_r, dlo_r};
		end
	end

	// ==========================================
	// Control register and data bytes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// [R8] permit cleared at power-up
			tgt_r <= 1'b0;
			permit_r <= 1'b0;
			start_r <= 1'b0;
			read_r <= 1'b0;
		end else if (soft_reset) begin
			permit_r <= 1'b0;
			start_r <= 1'b0;
			read_r <= 1'b0;
		end else begin
			if (w_ctl && st_r == ST_IDLE) begin
				tgt_r <= hwdata[CTL_TGT];
			end
			if (w_ctl) begin
				permit_r <= hwdata[CTL_PERMIT];
			end
			// [R15] start clears at the end
			if (go) begin
				start_r <= 1'b1;
			end else if (fin) begin
				start_r <= 1'b0;
			end
			if (rd_go) begin
				read_r <= 1'b1;
			end else if (st_r == ST_FETCH && cnt_r == 2'h0) begin
				read_r <= 1'b0;
			end
		end
	end

	// [R20] fault on reset mid-write; set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_r <= 1'b0;
		end else if (soft_reset && start_r) begin
			fault_r <= 1'b1;
		end else if (w_ctl) begin
			fault_r <= hwdata[CTL_FAULT];
		end
	end

	// [R15] sticky done flag; set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_r <= 1'b0;
			done_en_r <= 1'b0;
		end else begin
			if (fin) begin
				done_r <= 1'b1;
			end else if (w_flg) begin
				done_r <= hwdata[FLG_DONE];
			end
			if (w_en) begin
				done_en_r <= hwdata[FLG_DONE];
			end
		end
	end

	// Data and address bytes; [R17] fetched word lands in both
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dlo_r <= REG_RST;
			dhi_r <= REG_RST;
			alo_r <= REG_RST;
			ahi_r <= REG_RST;
		end else begin
			if (st_r == ST_FETCH && cnt_r == 2'h0) begin
				dlo_r <= mem_rdata[7:0];
				dhi_r <= mem_rdata[15:8];
			end else begin
				if (w_dlo) dlo_r <= hwdata[7:0];
				if (w_dhi) dhi_r <= hwdata[7:0];
			end
			if (w_alo) alo_r <= hwdata[7:0];
			if (w_ahi) ahi_r <= hwdata[7:0];
		end
	end

	// ==========================================
	// Memory, core and protection outputs
	logic code_nxt; // Target of the next cycle

	assign code_nxt = (st_r == ST_IDLE) ? hwdata[CTL_TGT] && w_ctl : tgt_r;

	// Registered memory commands; write and erase held until acknowledged, read held two fetch cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_read <= 1'b0;
			mem_write <= 1'b0;
			mem_erase <= 1'b0;
			mem_is_code <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
			core_stall <= 1'b0;
		end else begin
			mem_read <= st_nxt == ST_FETCH;
			mem_write <= st_nxt == ST_PROG;
			mem_erase <= st_nxt == ST_ERASE;
			mem_is_code <= code_nxt;
			mem_addr <= code_nxt ? code_addr : {8'h00, alo_r};
			if (st_nxt == ST_PROG || st_nxt == ST_ERASE) begin
				mem_addr <= {ahi_r, alo_r[7:2], widx_nxt};
				if (!tgt_r) mem_addr <= {8'h00, alo_r};
			end
			mem_wdata <= tgt_r ? buf_r[widx_nxt] : {8'h00, dlo_r};
			// [R4] two ignored cycles; [R5] release at finish
			core_stall <= code_nxt && st_nxt != ST_IDLE;
		end
	end

	// [R19] irq request; [R10] [R11] [R12] external gates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_irq_req <= 1'b0;
			ext_ee_access_en <= 1'b0;
			ext_code_read_en <= 1'b0;
			ext_code_write_en <= 1'b0;
		end else begin
			nvm_irq_req <= done_r && done_en_r;
			ext_ee_access_en <= !cfg_data_protect;
			ext_code_read_en <= !cfg_code_protect;
			ext_code_write_en <= !cfg_code_protect && !cfg_data_protect;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_start_unlock: assert property ($rose(start_r) |-> $past(armed) && $past(permit_r)) // [R2]
		else $error("write began without unlock and permit");
	a_pwrt_guard: assert property ($rose(start_r) && !tgt_r |-> !$past(pwrt_busy)) // [R9]
		else $error("EEPROM write during power-up timer");
	a_setup_stall: assert property ($rose(start_r) && tgt_r |-> core_stall ##1 core_stall) // [R4]
		else $error("code write did not stall two cycles");
	a_erase_last: assert property ($rose(mem_erase) |-> mem_is_code
		&& alo_r[1:0] == BLK_LAST) // [R16]
		else $error("erase outside last block word");
	a_done_set: assert property ($fell(start_r) && !$past(soft_reset) |-> done_r) // [R15]
		else $error("done flag not set at end");
	a_done_sticky: assert property (done_r && !w_flg |=> done_r) // [R15]
		else $error("done flag lost without clear");
	a_fault_reset: assert property (soft_reset && start_r |=> fault_r && !start_r) // [R20]
		else $error("reset mid-write did not flag fault");
	a_fetch_two: assert property ($rose(mem_read) |-> mem_read ##1 mem_read ##1 !mem_read) // [R17]
		else $error("fetch did not last two cycles");
	a_ext_code_wr: assert property (cfg_data_protect |=> !ext_code_write_en) // [R11]
		else $error("external code write open under EEPROM protect");
	a_irq_gate: assert property (nvm_irq_req |-> $past(done_r) && $past(done_en_r)) // [R19]
		else $error("irq request without flag and enable");
endmodule

// >>> nwc_tb.sv
// Self-checking bench for the NVM write control block over AHB-Lite
`timescale 1ns/10ps
module testbench;
	import nwc_pkg::*;
	// ==========================================================
	// Signals and bench state
	localparam int PWRT = 40; // Short power-up timer for simulation
	logic hclk, hresetn, hsel, hwrite, hready, soft_reset;
	logic [11:0] haddr;
	logic [1:0] htrans, protect_region_sel;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, r;
	logic hreadyout, hresp, cfg_data_protect, cfg_code_protect, mem_ack;
	logic [15:0] mem_rdata, mem_addr, mem_wdata, rd_word;
	logic mem_read, mem_write, mem_erase, mem_is_code, core_stall, nvm_irq_req;
	logic ext_ee_access_en, ext_code_read_en, ext_code_write_en;
	logic [32:0] mlog[$]; // Memory writes seen: {is_code, addr, data}
	int n_mismatch = 0, samples_checked = 0, stall_n = 0, rd_n = 0, n_erase = 0, ack_cnt = 0;
	assign hready = hreadyout; // Single slave: its ready is the bus ready
	nwc_top #(.PWRT_CYCLES(PWRT)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.soft_reset(soft_reset), .cfg_data_protect(cfg_data_protect),
		.cfg_code_protect(cfg_code_protect), .protect_region_sel(protect_region_sel),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_read(mem_read), .mem_write(mem_write),
		.mem_erase(mem_erase), .mem_is_code(mem_is_code), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .core_stall(core_stall), .nvm_irq_req(nvm_irq_req),
		.ext_ee_access_en(ext_ee_access_en), .ext_code_read_en(ext_code_read_en),
		.ext_code_write_en(ext_code_write_en));
	// Clock at 125 MHz
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// ==========================================================
	// Memory responder: acks each write or erase after a few cycles, logs writes and counts erases
	always @(posedge hclk) begin
		mem_rdata <= mem_read ? rd_word : ~rd_word;
		mem_ack <= 1'b0;
		if (core_stall === 1'b1) stall_n <= stall_n + 1;
		if (mem_read === 1'b1) rd_n <= rd_n + 1;
		if ((mem_write | mem_erase) === 1'b1 && !mem_ack) begin
			if (ack_cnt == 3) begin
				mem_ack <= 1'b1;
				ack_cnt <= 0;
				if (mem_erase) n_erase <= n_erase + 1;
				else mlog.push_back({mem_is_code, mem_addr, mem_wdata});
			end else ack_cnt <= ack_cnt + 1;
		end else ack_cnt <= 0;
	end
	// ==========================================================
	// Report and bus tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	// Waits for ready at a rising edge, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 20) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 20) begin
			$display("ERROR bus ready expected 1 seen timeout");
			n_mismatch++;
			close_out();
		end
	endtask
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd);
	endtask
	task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(nm, {25'h0, exp}, {1'b0, r});
		chk("hresp okay", 33'h0, {32'h0, hresp});
	endtask
	// Permit, two unlock keys (optionally broken), then start
	task automatic seq(input logic [7:0] ctl, input logic [7:0] k1, k2, input logic brk);
		wr(IDX_CONTROL, ctl);
		wr(IDX_UNLOCK, k1);
		if (brk) wr(IDX_ENABLE2, 8'h00);
		wr(IDX_UNLOCK, k2);
		wr(IDX_CONTROL, ctl | 8'h02);
	endtask
	// Polls until start clears, then checks the done flag without clearing it
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			bus(1'b0, IDX_CONTROL, 8'h00);
			n++;
		end while (r[CTL_START] !== 1'b0 && n < 60);
		chk("start cleared", 33'h0, {32'h0, n >= 60});
		rd_chk("done flag", IDX_FLAGS2, 8'h10);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, soft_reset, cfg_data_protect, cfg_code_protect} = 5'h00;
		haddr = 12'h000;
		htrans = 2'b00;
		hsize = 3'h2;
		hwdata = 32'h0;
		protect_region_sel = 2'h3;
		rd_word = 16'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk("control reset", IDX_CONTROL, 8'h00);
		// EEPROM write while the power-up timer runs
		wr(IDX_ADDR_LO, 8'h5a);
		wr(IDX_DATA_LO, 8'hc3);
		seq(8'h04, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		rd_chk("start blocked", IDX_CONTROL, 8'h04);
		rd_chk("flags reset", IDX_FLAGS2, 8'h00);
		rd_chk("enable reset", IDX_ENABLE2, 8'h00);
		wr(IDX_UNLOCK, UNLOCK_KEY1);
		rd_chk("unlock reads zero", IDX_UNLOCK, 8'h00);
		rd_chk("unmapped", 10'h3ff, 8'h00);
		$display("test reset and power-up done");
		repeat (PWRT) @(posedge hclk);
		// External access gates for each protect setting
		for (int i = 0; i < 4; i++) begin
			{cfg_code_protect, cfg_data_protect} <= i[1:0];
			repeat (3) @(posedge hclk);
			chk("ext ee", {32'h0, i[0] == 0}, {32'h0, ext_ee_access_en});
			chk("ext code rd", {32'h0, i[1] == 0}, {32'h0, ext_code_read_en});
			chk("ext code wr", {32'h0, i == 0}, {32'h0, ext_code_write_en});
		end
		$display("test protect gates done");
		// Internal EEPROM write with both protects on
		seq(8'h04, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		wait_done();
		chk("log size", 33'd1, 33'(mlog.size()));
		chk("ee write", {1'b0, 16'h005a, 16'h00c3}, mlog.pop_front());
		rd_chk("done sticky", IDX_FLAGS2, 8'h10);
		wr(IDX_ENABLE2, 8'h10);
		repeat (2) @(posedge hclk);
		chk("irq on", 33'h1, {32'h0, nvm_irq_req});
		wr(IDX_FLAGS2, 8'h00);
		repeat (2) @(posedge hclk);
		chk("irq off", 33'h0, {32'h0, nvm_irq_req});
		$display("test eeprom write done");
		// Refused sequences: no permit, keys swapped, unlock broken
		seq(8'h00, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		rd_chk("no permit", IDX_CONTROL, 8'h00);
		seq(8'h04, UNLOCK_KEY2, UNLOCK_KEY1, 1'b0);
		rd_chk("keys swapped", IDX_CONTROL, 8'h04);
		seq(8'h04, UNLOCK_KEY1, UNLOCK_KEY2, 1'b1);
		rd_chk("unlock broken", IDX_CONTROL, 8'h04);
		// Reset of the other kind during a write
		seq(8'h04, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		repeat (6) @(posedge hclk);
		rd_chk("fault after abort", IDX_CONTROL, 8'h08);
		chk("no write", 33'd0, 33'(mlog.size()));
		wr(IDX_CONTROL, 8'h00);
		rd_chk("fault cleared", IDX_CONTROL, 8'h00);
		$display("test refusals done");
		// Four-word code block, written in order 00,01,10,11
		wr(IDX_ADDR_HI, 8'h20);
		for (int w = 0; w < 4; w++) begin
			wr(IDX_ADDR_LO, 8'(w));
			wr(IDX_DATA_LO, 8'(8'h10 + w));
			wr(IDX_DATA_HI, 8'(8'ha0 + w));
			stall_n = 0;
			seq(8'h84, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
			wait_done();
			wr(IDX_FLAGS2, 8'h00);
			if (w < 3) begin
				chk("setup stall", 33'd2, 33'(stall_n));
				chk("buffer only", 33'd0, 33'(mlog.size()));
			end
		end
		chk("erase count", 33'd1, 33'(n_erase));
		chk("prog count", 33'd4, 33'(mlog.size()));
		for (int w = 0; w < 4; w++) begin
			chk("code word", {1'b1, 16'(16'h2000 + w), 8'(8'ha0 + w), 8'(8'h10 + w)},
				mlog.pop_front());
		end
		$display("test code block done");
		// Region select 2: below 0x0100 protected, 0x0100 allowed
		protect_region_sel <= 2'h2;
		wr(IDX_ADDR_HI, 8'h00);
		wr(IDX_ADDR_LO, 8'hfc);
		seq(8'h84, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		rd_chk("protected region", IDX_CONTROL, 8'h84);
		wr(IDX_ADDR_HI, 8'h01);
		wr(IDX_ADDR_LO, 8'h00);
		seq(8'h84, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		wait_done();
		wr(IDX_FLAGS2, 8'h00);
		// Skipping word 01 is ignored
		wr(IDX_ADDR_LO, 8'h02);
		seq(8'h84, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
		rd_chk("wrong word", IDX_CONTROL, 8'h84);
		chk("nothing programmed", 33'd0, 33'(mlog.size()));
		$display("test regions done");
		// Code read: two fetch cycles, word into both data registers
		rd_word = 16'hbeef;
		rd_n = 0;
		wr(IDX_CONTROL, 8'h81);
		// Two ignored cycles before the fetched word is usable
		repeat (2) @(posedge hclk);
		rd_chk("read low", IDX_DATA_LO, 8'hef);
		rd_chk("read high", IDX_DATA_HI, 8'hbe);
		chk("fetch cycles", 33'd2, 33'(rd_n));
		// EEPROM read: same fetch, no core stall
		rd_word = 16'h5a3c;
		rd_n = 0;
		stall_n = 0;
		wr(IDX_CONTROL, 8'h01);
		repeat (2) @(posedge hclk);
		rd_chk("ee read low", IDX_DATA_LO, 8'h3c);
		chk("ee read stall", 33'd0, 33'(stall_n));
		chk("ee fetch cycles", 33'd2, 33'(rd_n));
		$display("test code read done");
		close_out();
	end
endmodule
